// >>> tf_cfg.svh
// Constants shared by both ends of the task-file link.
`ifndef TF_CFG_SVH
`define TF_CFG_SVH

`define CLK_PERIOD_NS   50
`define SLAVE_WAIT_S    5
`define DIAG_TEST_CYC   32'h0000_0040

`define CMD_DIAG        8'h90
`define CMD_INIT        8'h91
`define CMD_RDMUL       8'hC4
`define CMD_WRMUL       8'hC5
`define CMD_SETMUL      8'hC6
`define CMD_RDBUF       8'hE4
`define CMD_WRBUF       8'hE8
`define CMD_IDENT       8'hEC
`define CMD_BUFMODE     8'hEF

`define DIAG_OK         8'h01
`define DIAG_BUF_ERR    8'h03
`define DIAG_SLAVE_FAIL 8'h80
`define DIAG_SLAVE_MASK 8'h7F
`define ERR_ABRT        8'h04
`define ERR_UNC         8'h40
`define TF_INIT_ONE     8'h01
`define TF_INIT_ZERO    8'h00

`define DEF_SECTORS     8'h21
`define DEF_HEAD_LIMIT  4'h7
`define DEF_CYLS        16'h0308
`define TOTAL_SECTORS   18'h32040
`define MAX_BLOCK       8'h40
`define LA_ON           8'hAA
`define LA_OFF          8'h55

`define SECTOR_WORDS    15'h0100
`define BUF_WORDS       16384
`define ID_W0           16'h0A5A
`define ID_W20          16'h0003
`define ID_HEADS        16'h0008
`define ID_BUF_SIZE     16'h0040
`define ID_ECC_BYTES    16'h0007
`define ID_MAX_BLOCK    16'h0040

`define TF_DATA         3'h0
`define TF_ERR_PRECOMP  3'h1
`define TF_SECCNT       3'h2
`define TF_SECNUM       3'h3
`define TF_CYL_LO       3'h4
`define TF_CYL_HI       3'h5
`define TF_DRV_HEAD     3'h6
`define TF_STAT_CMD     3'h7
`define HOST_REG_IRQ    4'h8
`define HOST_REG_HEADS  4'h9

`define ST_BSY          7
`define ST_DRDY         6
`define ST_DSC          4
`define ST_DRQ          3
`define ST_CORR         2
`define ST_ERR          0

`endif

// >>> tf_pkg.sv
// Types shared by both ends of the task-file link.
package tf_pkg;
	typedef enum logic [7:0] {
		S_IDLE  = 8'h01,
		S_EXEC  = 8'h02,
		S_DIAG  = 8'h04,
		S_SLAVE = 8'h08,
		S_FILL  = 8'h10,
		S_NEXT  = 8'h20,
		S_MEDIA = 8'h40,
		S_XFER  = 8'h80
	} dev_state_t;

	typedef enum logic [1:0] {
		M_OK    = 2'h0,
		M_CORR  = 2'h1,
		M_FATAL = 2'h2,
		M_RSVD  = 2'h3
	} media_err_t;
endpackage : tf_pkg

// >>> tf_if.sv
// Task-file register port between the host adapter and the drive.
`timescale 1ns/100ps
`default_nettype none
interface tf_if;
	logic [2:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        irq;

	modport device (input addr, input wdata, input wr, input rd, output rdata, output irq);
	modport host   (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface : tf_if
`default_nettype wire

// >>> tf_drive.sv
// Drive end of the task-file link: command execution and the sector buffer.
`timescale 1ns/100ps
`default_nettype none
`include "tf_cfg.svh"
// Contract
// - Diagnostic command sets busy, runs self tests.
// - Master waits up to 5 s for slave.
// - Diagnostic result is a code: 01, 03.
// - Slave failure ORs 80h, else bit 7 cleared.
// - Diagnostic end loads initial values, interrupts.
// - Init parameters stores limits without validity checks.
// - Default geometry 33 sectors, 8 heads, 776.
// - Head limit is count minus one; cylinders derived.
// - Advance head at sector limit, cylinder at head.
// - Multiple commands abort unless block mode enabled.
// - Full blocks first, then remainder partial block.
// - Read errors reported at block start; correctable continues.
// - One interrupt with data request per block.
// - No look-ahead during read multiple.
// - Write multiple busy at once, first block silent.
// - Write error ends at failing sector, stops.
// - Set multiple takes 1..64 powers of two.
// - Bad size aborts, zero disables; then interrupt.
// - Read buffer: data request, interrupt, 512 bytes.
// - Write buffer: data request, host writes 512 bytes.
// - Identify fills 256-word page, reserved zero.
// - Buffer mode AAh on, 55h off, else abort.
// - While busy, reads give status, writes ignored.
// - Initial task file values 01 and 00.
module tf_drive #(
	parameter int unsigned SLAVE_WAIT_CYC =
		32'(64'(`SLAVE_WAIT_S) * 64'd1000000000 / 64'(`CLK_PERIOD_NS))
) (
	// Clock and reset.
	input  wire logic               clk_in,
	input  wire logic               reset_in,
	// Task-file port.
	tf_if.device                    tf,
	// Diagnostic pins.
	input  wire logic               master_strap_in,
	input  wire logic               slave_present_in,
	input  wire logic               passed_diagnostic_line_n_in,
	output logic                    passed_diagnostic_line_n_out,
	output logic                    passed_diagnostic_line_oe_n_out,
	input  wire logic               self_test_fail_in,
	// Media side.
	output logic                    media_req_out,
	output logic                    media_write_out,
	output logic [15:0]             media_cyl_out,
	output logic [3:0]              media_head_out,
	output logic [7:0]              media_sector_out,
	input  wire logic               media_word_valid_in,
	input  wire logic [15:0]        media_word_in,
	input  wire logic               media_word_take_in,
	output logic [15:0]             media_word_out,
	input  wire logic               media_done_in,
	input  wire tf_pkg::media_err_t media_err_in,
	// Status.
	output logic                    look_ahead_out,
	output logic                    busy_out
);
	import tf_pkg::*;

	typedef struct packed {
		dev_state_t  state;
		logic        busy, data_request_flag, err, corr, irq, first, blk_en, look_ahead, la_act;
		logic        media_req, media_write, pdiag_drive;
		logic [7:0]  errreg, seccnt, secnum, cyll, cylh, drvhd, precomp, cmd, diag_code;
		logic [6:0]  blk_size, blk_left;
		logic [3:0]  max_head;
		logic [7:0]  max_sec;
		logic [15:0] max_cyl, rdata;
		logic [31:0] cnt;
		logic [13:0] ptr;
		logic [14:0] wlen;
		logic [8:0]  remain;
		media_err_t  blk_err;
		logic [1:0]  strap_s, pres_s, pdiag_s;
	} drive_st_t;

	localparam drive_st_t ST_RST = '{default: '0, state: S_IDLE, errreg: `TF_INIT_ONE,
		seccnt: `TF_INIT_ONE, secnum: `TF_INIT_ONE, max_sec: `DEF_SECTORS,
		max_head: `DEF_HEAD_LIMIT, max_cyl: `DEF_CYLS, look_ahead: 1'b1, la_act: 1'b1,
		blk_err: M_OK, strap_s: 2'h3, pdiag_s: 2'h3};

	drive_st_t   st, nx;
	logic [15:0] mem [0:`BUF_WORDS-1];
	logic [15:0] mem_q, mem_wd;
	logic        mem_we, xfer_end, fin, abort;
	logic [7:0]  status, adv_sec;
	logic [3:0]  adv_head;
	logic [15:0] adv_cyl;
	logic [6:0]  blk_n;
	logic [11:0] geo_prod;
	media_err_t  worst;

	function automatic logic [15:0] id_word(input logic [7:0] idx);
		case (idx)
			8'h00: id_word = `ID_W0;
			8'h01: id_word = `DEF_CYLS;
			8'h03: id_word = `ID_HEADS;
			8'h06: id_word = {8'h00, `DEF_SECTORS};
			8'h14: id_word = `ID_W20;
			8'h15: id_word = `ID_BUF_SIZE;
			8'h16: id_word = `ID_ECC_BYTES;
			8'h2F: id_word = `ID_MAX_BLOCK;
			default: id_word = 16'h0000;
		endcase
	endfunction : id_word

	always_comb begin
		nx = st;
		nx.irq = 1'b0;
		nx.media_req = 1'b0;
		mem_we = 1'b0;
		mem_wd = tf.wdata;
		xfer_end = 1'b0;
		fin = 1'b0;
		abort = 1'b0;
		worst = st.blk_err;
		nx.strap_s = {st.strap_s[0], master_strap_in};
		nx.pres_s = {st.pres_s[0], slave_present_in};
		nx.pdiag_s = {st.pdiag_s[0], passed_diagnostic_line_n_in};
		status = 8'h00;
		status[`ST_BSY] = st.busy;
		status[`ST_DRDY] = 1'b1;
		status[`ST_DSC] = 1'b1;
		status[`ST_DRQ] = st.data_request_flag;
		status[`ST_CORR] = st.corr;
		status[`ST_ERR] = st.err;
		blk_n = (st.remain < {2'b00, st.blk_size}) ? st.remain[6:0] : st.blk_size;
		geo_prod = 12'(({1'b0, st.drvhd[3:0]} + 5'h01) * st.seccnt);
		// Next sector address after the current one is done.
		adv_sec = st.secnum + 8'h01;
		adv_head = st.drvhd[3:0];
		adv_cyl = {st.cylh, st.cyll};
		if (st.secnum >= st.max_sec) begin
			adv_sec = 8'h01;
			adv_head = st.drvhd[3:0] + 4'h1;
			if (st.drvhd[3:0] >= st.max_head) begin
				adv_head = 4'h0;
				adv_cyl = adv_cyl + 16'h0001;
			end
		end
		// Host reads and writes.
		if (tf.rd) begin
			if (st.busy) begin
				nx.rdata = {8'h00, status};
			end else begin
				case (tf.addr)
					`TF_DATA: begin
						nx.rdata = mem_q;
						if (st.data_request_flag && st.cmd != `CMD_WRMUL && st.cmd != `CMD_WRBUF) begin
							nx.ptr = st.ptr + 14'h0001;
							nx.wlen = st.wlen - 15'h0001;
							xfer_end = (st.wlen == 15'h0001);
						end
					end
					`TF_ERR_PRECOMP: nx.rdata = {8'h00, st.errreg};
					`TF_SECCNT: nx.rdata = {8'h00, st.seccnt};
					`TF_SECNUM: nx.rdata = {8'h00, st.secnum};
					`TF_CYL_LO: nx.rdata = {8'h00, st.cyll};
					`TF_CYL_HI: nx.rdata = {8'h00, st.cylh};
					`TF_DRV_HEAD: nx.rdata = {8'h00, st.drvhd};
					default: nx.rdata = {8'h00, status};
				endcase
			end
		end
		if (tf.wr && !st.busy) begin
			case (tf.addr)
				`TF_DATA: begin
					if (st.data_request_flag && (st.cmd == `CMD_WRMUL || st.cmd == `CMD_WRBUF)) begin
						mem_we = 1'b1;
						nx.ptr = st.ptr + 14'h0001;
						nx.wlen = st.wlen - 15'h0001;
						xfer_end = (st.wlen == 15'h0001);
					end
				end
				`TF_ERR_PRECOMP: nx.precomp = tf.wdata[7:0];
				`TF_SECCNT: nx.seccnt = tf.wdata[7:0];
				`TF_SECNUM: nx.secnum = tf.wdata[7:0];
				`TF_CYL_LO: nx.cyll = tf.wdata[7:0];
				`TF_CYL_HI: nx.cylh = tf.wdata[7:0];
				`TF_DRV_HEAD: nx.drvhd = tf.wdata[7:0];
				default: begin
					nx.cmd = tf.wdata[7:0];
					nx.busy = 1'b1;
					nx.data_request_flag = 1'b0;
					nx.err = 1'b0;
					nx.corr = 1'b0;
					nx.pdiag_drive = 1'b0;
					nx.state = S_EXEC;
				end
			endcase
		end
		case (st.state)
			S_EXEC: begin
				case (st.cmd)
					`CMD_DIAG: begin
						nx.cnt = `DIAG_TEST_CYC;
						nx.state = S_DIAG;
					end
					`CMD_INIT: begin
						nx.max_head = st.drvhd[3:0];
						nx.max_sec = st.seccnt;
						nx.max_cyl = (geo_prod == 12'h000) ? 16'h0000 :
							16'(`TOTAL_SECTORS / geo_prod);
						fin = 1'b1;
					end
					`CMD_RDMUL, `CMD_WRMUL: begin
						if (!st.blk_en) begin
							abort = 1'b1;
						end else begin
							nx.remain = (st.seccnt == 8'h00) ? 9'h100 : {1'b0, st.seccnt};
							nx.first = 1'b1;
							nx.state = S_NEXT;
						end
					end
					`CMD_SETMUL: begin
						nx.blk_en = 1'b0;
						if (st.seccnt != 8'h00 && st.seccnt <= `MAX_BLOCK &&
							(st.seccnt & (st.seccnt - 8'h01)) == 8'h00) begin
							nx.blk_en = 1'b1;
							nx.blk_size = st.seccnt[6:0];
						end else if (st.seccnt != 8'h00) begin
							abort = 1'b1;
						end
						fin = 1'b1;
					end
					`CMD_RDBUF, `CMD_WRBUF: begin
						nx.ptr = 14'h0000;
						nx.wlen = `SECTOR_WORDS;
						nx.data_request_flag = 1'b1;
						nx.busy = 1'b0;
						nx.irq = (st.cmd == `CMD_RDBUF);
						nx.state = S_XFER;
					end
					`CMD_IDENT: begin
						nx.ptr = 14'h0000;
						nx.state = S_FILL;
					end
					`CMD_BUFMODE: begin
						if (st.precomp == `LA_ON) nx.look_ahead = 1'b1;
						else if (st.precomp == `LA_OFF) nx.look_ahead = 1'b0;
						else abort = 1'b1;
						fin = 1'b1;
					end
					default: abort = 1'b1;
				endcase
			end
			S_DIAG: begin
				nx.cnt = st.cnt - 32'h1;
				if (st.cnt == 32'h0) begin
					nx.diag_code = self_test_fail_in ? `DIAG_BUF_ERR : `DIAG_OK;
					nx.cnt = SLAVE_WAIT_CYC;
					if (st.strap_s[1] && st.pres_s[1]) nx.state = S_SLAVE;
					else fin = 1'b1;
				end
			end
			S_SLAVE: begin
				nx.cnt = st.cnt - 32'h1;
				if (!st.pdiag_s[1]) begin
					nx.diag_code = st.diag_code & `DIAG_SLAVE_MASK;
					fin = 1'b1;
				end else if (st.cnt == 32'h0) begin
					nx.diag_code = st.diag_code | `DIAG_SLAVE_FAIL;
					fin = 1'b1;
				end
			end
			S_FILL: begin
				mem_we = 1'b1;
				mem_wd = id_word(st.ptr[7:0]);
				nx.ptr = st.ptr + 14'h0001;
				if (st.ptr[7:0] == 8'hFF) begin
					nx.ptr = 14'h0000;
					nx.wlen = `SECTOR_WORDS;
					nx.data_request_flag = 1'b1;
					nx.busy = 1'b0;
					nx.irq = 1'b1;
					nx.state = S_XFER;
				end
			end
			S_NEXT: begin
				nx.blk_left = blk_n;
				nx.blk_err = M_OK;
				nx.ptr = 14'h0000;
				nx.wlen = {blk_n, 8'h00};
				if (st.cmd == `CMD_RDMUL) begin
					nx.media_req = 1'b1;
					nx.media_write = 1'b0;
					nx.state = S_MEDIA;
				end else begin
					nx.data_request_flag = 1'b1;
					nx.busy = 1'b0;
					nx.irq = !st.first;
					nx.first = 1'b0;
					nx.state = S_XFER;
				end
			end
			S_MEDIA: begin
				if (media_word_valid_in && !st.media_write) begin
					mem_we = 1'b1;
					mem_wd = media_word_in;
					nx.ptr = st.ptr + 14'h0001;
				end
				if (media_word_take_in && st.media_write) nx.ptr = st.ptr + 14'h0001;
				if (media_done_in) begin
					if (media_err_in > st.blk_err) worst = media_err_in;
					nx.blk_err = worst;
					nx.blk_left = st.blk_left - 7'h01;
					if (!st.media_write || media_err_in == M_OK) begin
						if (media_err_in != M_FATAL) begin
							nx.secnum = adv_sec;
							nx.drvhd[3:0] = adv_head;
							{nx.cylh, nx.cyll} = adv_cyl;
							nx.seccnt = st.seccnt - 8'h01;
							nx.remain = st.remain - 9'h001;
						end
					end
					if (st.media_write && media_err_in != M_OK) begin
						nx.err = 1'b1;
						nx.errreg = `ERR_UNC;
						fin = 1'b1;
					end else if (st.blk_left != 7'h01 && media_err_in != M_FATAL) begin
						nx.media_req = 1'b1;
					end else if (st.media_write) begin
						if (st.remain == 9'h001) fin = 1'b1;
						else nx.state = S_NEXT;
					end else begin
						nx.ptr = 14'h0000;
						nx.data_request_flag = 1'b1;
						nx.busy = 1'b0;
						nx.irq = 1'b1;
						nx.err = (worst == M_FATAL);
						nx.corr = (worst == M_CORR);
						if (worst == M_FATAL) nx.errreg = `ERR_UNC;
						nx.state = S_XFER;
					end
				end
			end
			S_XFER: begin
				if (xfer_end) begin
					nx.data_request_flag = 1'b0;
					nx.state = S_IDLE;
					if (st.cmd == `CMD_RDMUL && st.blk_err != M_FATAL && st.remain != 9'h000) begin
						nx.busy = 1'b1;
						nx.state = S_NEXT;
					end else if (st.cmd == `CMD_WRMUL) begin
						nx.busy = 1'b1;
						nx.ptr = 14'h0000;
						nx.media_req = 1'b1;
						nx.media_write = 1'b1;
						nx.state = S_MEDIA;
					end
				end
			end
			default: ;
		endcase
		if (fin && st.cmd == `CMD_DIAG) begin
			nx.errreg = nx.diag_code;
			nx.err = (nx.diag_code != `DIAG_OK);
			nx.seccnt = `TF_INIT_ONE;
			nx.secnum = `TF_INIT_ONE;
			nx.cyll = `TF_INIT_ZERO;
			nx.cylh = `TF_INIT_ZERO;
			nx.drvhd = `TF_INIT_ZERO;
			nx.pdiag_drive = !st.strap_s[1] && nx.diag_code == `DIAG_OK;
		end
		if (abort) begin
			nx.err = 1'b1;
			nx.errreg = `ERR_ABRT;
		end
		if (fin || abort) begin
			nx.busy = 1'b0;
			nx.data_request_flag = 1'b0;
			nx.irq = 1'b1;
			nx.state = S_IDLE;
		end
		nx.la_act = nx.look_ahead && !(st.cmd == `CMD_RDMUL && nx.state != S_IDLE);
		if (reset_in) nx = ST_RST;
	end

	always_ff @(posedge clk_in) begin
		st <= nx;
	end

	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem[st.ptr] <= mem_wd;
		end
		mem_q <= mem[nx.ptr];
	end

	assign tf.rdata = st.rdata;
	assign tf.irq = st.irq;
	assign passed_diagnostic_line_n_out = 1'b0;
	assign passed_diagnostic_line_oe_n_out = !st.pdiag_drive;
	assign media_req_out = st.media_req;
	assign media_write_out = st.media_write;
	assign media_cyl_out = {st.cylh, st.cyll};
	assign media_head_out = st.drvhd[3:0];
	assign media_sector_out = st.secnum;
	assign media_word_out = mem_q;
	assign look_ahead_out = st.la_act;
	assign busy_out = st.busy;
endmodule : tf_drive
`default_nettype wire

// >>> tf_host.sv
// Host end of the task-file link: register port adapter with interrupt tally.
`timescale 1ns/100ps
`default_nettype none
`include "tf_cfg.svh"
module tf_host (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// Software register port.
	input  wire logic [3:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out,
	output logic             irq_out,
	// Task-file port.
	tf_if.host               tf
);
	import tf_pkg::*;

	typedef struct packed {
		logic       own_rd;
		logic       irq_sticky;
		logic [7:0] irq_count;
	} host_st_t;

	host_st_t st, nx;

	always_comb begin
		nx = st;
		nx.own_rd = rd_in && (addr_in == `HOST_REG_IRQ);
		if (wr_in && addr_in == `HOST_REG_IRQ && wdata_in[0]) nx.irq_sticky = 1'b0;
		// Each drive interrupt sets the sticky flag and adds one to the tally; a set beats a clear.
		if (tf.irq) begin
			nx.irq_sticky = 1'b1;
			nx.irq_count = st.irq_count + 8'h01;
		end
		if (reset_in) nx = '0;
	end

	always_ff @(posedge clk_in) begin
		st <= nx;
	end

	always_comb begin
		tf.addr = addr_in[2:0];
		tf.wdata = wdata_in;
		tf.wr = wr_in && !addr_in[3];
		tf.rd = rd_in && !addr_in[3];
		if (addr_in == `HOST_REG_HEADS) begin
			// Software gives the head count; the drive wants it less one.
			tf.addr = `TF_DRV_HEAD;
			tf.wdata = {8'h00, wdata_in[7:4], wdata_in[3:0] - 4'h1};
			tf.wr = wr_in;
		end
	end

	assign rdata_out = st.own_rd ? {st.irq_count, 7'h00, st.irq_sticky} : tf.rdata;
	assign irq_out = st.irq_sticky;
endmodule : tf_host
`default_nettype wire

// >>> tf_link_assertions.sv
// Concurrent checks on the task-file link between host adapter and drive.
`timescale 1ns/100ps
`default_nettype none
module tf_link_checker (
	// Clock and reset.
	input wire logic        clk_in,
	input wire logic        reset_in,
	// Link signals.
	input wire logic [2:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        irq
);
	logic [7:0] cnt_q;
	logic       blk_q;
	logic       cmd;
	logic [7:0] op;
	assign cmd = wr && (addr == 3'h7);
	assign op  = wdata[7:0];
	// Mirrors the sector count and the block-mode enable that the host has set up.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_q <= 8'h00;
			blk_q <= 1'b0;
		end else begin
			if (wr && (addr == 3'h2))
				cnt_q <= op;
			if (cmd && (op == 8'hC6))
				blk_q <= cnt_q inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_irq_pulse; irq |=> !irq; endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("irq longer than one cycle");
	property p_status; rd && (addr == 3'h7) |=> rdata[15:8] == 8'h00 && rdata[6] && rdata[4];
	endproperty
	a_status: assert property (p_status)
		else $error("status byte malformed");
	property p_hold; !rd |=> $stable(rdata); endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	property p_short; cmd && (op inside {8'h91, 8'hC6, 8'hEF}) |-> ##2 irq; endproperty
	a_short: assert property (p_short)
		else $error("short command did not interrupt");
	property p_rdbuf; cmd && (op == 8'hE4) |-> ##[1:8] irq; endproperty
	a_rdbuf: assert property (p_rdbuf)
		else $error("read buffer did not interrupt");
	property p_wrbuf; cmd && (op == 8'hE8) |=> !irq [*8]; endproperty
	a_wrbuf: assert property (p_wrbuf)
		else $error("write buffer interrupted");
	property p_diag_quiet; cmd && (op == 8'h90) |=> !irq [*8]; endproperty
	a_diag_quiet: assert property (p_diag_quiet)
		else $error("diagnostic ended too soon");
	property p_diag_done; cmd && (op == 8'h90) |-> ##[60:600] irq; endproperty
	a_diag_done: assert property (p_diag_done)
		else $error("diagnostic never finished");
	property p_wrmul; cmd && (op == 8'hC5) && blk_q |=> !irq [*8]; endproperty
	a_wrmul: assert property (p_wrmul)
		else $error("interrupt before first write block");
	property p_abort; cmd && (op == 8'hC4) && !blk_q |-> ##[1:4] irq; endproperty
	a_abort: assert property (p_abort)
		else $error("read multiple not rejected");
endmodule : tf_link_checker
`default_nettype wire

// >>> tb_disk_task_file_command_exec.sv
// Self-checking bench for the host adapter and drive joined over the task-file link.
`timescale 1ns/100ps
`default_nettype none
`include "tf_cfg.svh"
module tb_disk_task_file_command_exec;
	import tf_pkg::*;
	logic        clk_in, reset_in, wr_in, rd_in, irq_out;
	logic [3:0]  addr_in;
	logic [15:0] wdata_in, rdata_out, rv, mv, m_word, m_out, m_cyl;
	logic        master, present, line_n, self_fail, pd_n, pd_oe_n, la, busy;
	logic        m_req, m_wr, m_valid, m_take, m_done;
	logic [3:0]  m_head;
	logic [7:0]  m_sec, ex;
	media_err_t  m_err, m_err_nx;
	logic [31:0] seed;
	logic [15:0] q[$], cq[$];
	logic [27:0] aq[$];
	int          error_cnt, samples_checked, irq_seen;
	logic [27:0] ea[3] = '{28'h0000002, 28'h0000101, 28'h0000102};
	logic [2:0]  dg[3] = '{3'b110, 3'b100, 3'b011};
	logic [7:0]  sz[5] = '{8'h03, 8'h40, 8'h41, 8'h01, 8'h00};
	logic [7:0]  pm[3] = '{8'h55, 8'h33, 8'hAA};
	tf_if link();
	tf_host tf_host_i (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.irq_out(irq_out), .tf(link));
	tf_drive #(.SLAVE_WAIT_CYC(200)) tf_drive_i (.clk_in(clk_in), .reset_in(reset_in),
		.tf(link), .master_strap_in(master), .slave_present_in(present),
		.passed_diagnostic_line_n_in((pd_oe_n | pd_n) & line_n),
		.passed_diagnostic_line_n_out(pd_n), .passed_diagnostic_line_oe_n_out(pd_oe_n),
		.self_test_fail_in(self_fail), .media_req_out(m_req), .media_write_out(m_wr),
		.media_cyl_out(m_cyl), .media_head_out(m_head), .media_sector_out(m_sec),
		.media_word_valid_in(m_valid), .media_word_in(m_word), .media_word_take_in(m_take),
		.media_word_out(m_out), .media_done_in(m_done), .media_err_in(m_err),
		.look_ahead_out(la), .busy_out(busy));
	tf_link_checker tf_link_checker_i (.clk_in(clk_in), .reset_in(reset_in),
		.addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
		.rdata(link.rdata), .irq(link.irq));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	function automatic logic [15:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[15:0];
	endfunction : rnd
	function automatic logic [15:0] id_word(input int w);
		case (w)
			0: return `ID_W0;
			1: return `DEF_CYLS;
			3: return `ID_HEADS;
			6: return {8'h00, `DEF_SECTORS};
			20: return `ID_W20;
			21: return `ID_BUF_SIZE;
			22: return `ID_ECC_BYTES;
			47: return `ID_MAX_BLOCK;
			default: return 16'h0000;
		endcase
	endfunction : id_word
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		#1 rv = rdata_out;
	endtask : rd_reg
	// Waits for the sticky host interrupt, or for data request when irq is not expected.
	task automatic wait_for(input bit use_irq, input int lim);
		int n;
		n = 0;
		do begin
			if (use_irq)
				@(posedge clk_in);
			else
				rd_reg(4'h7);
			#2 n++;
			if (n > lim) begin
				error_cnt++;
				give_verdict();
			end
		end while (use_irq ? irq_out !== 1'b1 : rv[3] !== 1'b1);
		if (use_irq) begin
			irq_seen++;
			wr_reg(4'h8, 16'h0001);
		end
	endtask : wait_for
	task automatic cmd_irq(input logic [7:0] c);
		wr_reg(4'h7, {8'h00, c});
		wait_for(1'b1, 2000);
	endtask : cmd_irq
	task automatic read_words(input int n, input bit ident);
		for (int i = 0; i < n; i++) begin
			rd_reg(4'h0);
			check("data word", rv, ident ? id_word(i) : q.pop_front());
		end
	endtask : read_words
	task automatic write_words(input int n);
		for (int i = 0; i < n; i++) begin
			mv = rnd();
			q.push_back(mv);
			wr_reg(4'h0, mv);
		end
	endtask : write_words
	// Media stand-in: serves each sector request and records where it was aimed.
	initial begin
		forever begin
			@(posedge clk_in);
			if (m_req === 1'b1) begin
				aq.push_back({m_cyl, m_head, m_sec});
				m_take <= m_wr;
				for (int k = 0; k < 256; k++) begin
					if (m_wr === 1'b1) begin
						@(posedge clk_in);
						cq.push_back(m_out);
					end else begin
						mv = rnd();
						m_valid <= 1'b1;
						m_word  <= mv;
						q.push_back(mv);
						@(posedge clk_in);
					end
				end
				m_take   <= 1'b0;
				m_valid  <= 1'b0;
				m_done   <= 1'b1;
				m_err    <= m_err_nx;
				m_err_nx = M_OK;
				@(posedge clk_in);
				m_done   <= 1'b0;
			end
		end
	end
	initial begin
		{reset_in, wr_in, rd_in, addr_in, wdata_in} = {1'b1, 22'h0};
		{present, line_n, self_fail, m_valid, m_take, m_done, m_word} = 22'h100000;
		master = 1'b1;
		irq_seen = 0;
		m_err = M_OK;
		m_err_nx = M_OK;
		seed = 32'h9940;
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		rd_reg(4'h7);
		check("status", rv, 16'h0050);
		check("look ahead", la, 1'b1);
		for (int i = 1; i < 7; i++) begin
			rd_reg(i[3:0]);
			check("task file", rv, (i < 4) ? 16'h0001 : 16'h0000);
		end
		for (int i = 0; i < 3; i++) begin
			wr_reg(4'h1, {8'h00, pm[i]});
			cmd_irq(8'hEF);
			rd_reg(4'h7);
			check("mode abort", rv[0], pm[i] == 8'h33);
			check("look ahead", la, pm[i] == 8'hAA);
		end
		for (int i = 0; i < 5; i++) begin
			wr_reg(4'h2, {8'h00, sz[i]});
			cmd_irq(8'hC6);
			rd_reg(4'h7);
			check("size abort", rv[0], sz[i] inside {8'h03, 8'h41});
		end
		cmd_irq(8'hC4);
		rd_reg(4'h1);
		check("abort code", rv, `ERR_ABRT);
		wr_reg(4'h7, 16'h00E8);
		wait_for(1'b0, 50);
		write_words(256);
		cmd_irq(8'hE4);
		read_words(256, 1'b0);
		wr_reg(4'h7, 16'h00EC);
		rd_reg(4'h2);
		check("busy read", rv, 16'h00D0);
		check("busy pin", busy, 1'b1);
		wr_reg(4'h3, 16'h0055);
		wait_for(1'b1, 2000);
		read_words(256, 1'b1);
		rd_reg(4'h3);
		check("busy write", rv, 16'h0001);
		wr_reg(4'h9, 16'h0002);
		wr_reg(4'h2, 16'h0002);
		cmd_irq(8'h91);
		wr_reg(4'h2, 16'h0002);
		cmd_irq(8'hC6);
		wr_reg(4'h3, 16'h0002);
		wr_reg(4'h6, 16'h0000);
		wr_reg(4'h2, 16'h0003);
		m_err_nx = M_CORR;
		wr_reg(4'h7, 16'h00C4);
		for (int b = 0; b < 2; b++) begin
			wait_for(1'b1, 3000);
			rd_reg(4'h7);
			check("block status", rv[3:2], b ? 2'h2 : 2'h3);
			check("look ahead", la, 1'b0);
			read_words(b ? 256 : 512, 1'b0);
		end
		for (int i = 0; i < 3; i++)
			check("media place", aq.pop_front(), ea[i]);
		wr_reg(4'h2, 16'h0001);
		m_err_nx = M_FATAL;
		wr_reg(4'h7, 16'h00C5);
		wait_for(1'b0, 50);
		write_words(256);
		wait_for(1'b1, 2000);
		rd_reg(4'h1);
		check("write error", rv, `ERR_UNC);
		for (int i = 0; i < 256; i++)
			check("media word", cq.pop_front(), q.pop_front());
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_in);
			{present, line_n, self_fail} <= dg[i];
			ex = (dg[i][0] ? `DIAG_BUF_ERR : `DIAG_OK) | ((dg[i][2:1] == 2'h3) ? 8'h80 : 8'h00);
			cmd_irq(8'h90);
			rd_reg(4'h1);
			check("diag code", rv, {8'h00, ex});
			rd_reg(4'h2);
			check("reinit", rv, 16'h0001);
			rd_reg(4'h4);
			check("reinit cyl", rv, 16'h0000);
		end
		// Strapped as slave the drive pulls the pass line low after a clean test.
		@(posedge clk_in);
		{master, present, line_n, self_fail} <= 4'b0010;
		cmd_irq(8'h90);
		check("pass line", pd_oe_n, 1'b0);
		rd_reg(4'h1);
		check("slave code", rv, {8'h00, `DIAG_OK});
		rd_reg(4'h8);
		check("irq tally", rv, {irq_seen[7:0], 8'h00});
		give_verdict();
	end
endmodule : tb_disk_task_file_command_exec
`default_nettype wire
